/* rtl/dwc_crc8_72.sv */
// Parallel 8-bit checksum over a 72-bit code word
`timescale 1ns/10ps
module dwc_crc8_72 (
   input  wire logic [71:0] i_data,   // Code word, bit 71 sent first
   output logic      [7:0]  o_crc     // Checksum
);
   import dwc_pkg::*;

   // Serial shift unrolled into an XOR tree, start value zero, x^8+x^2+x+1
   always_comb begin
      logic [7:0] c;
      logic       fb;
      c  = 8'h00;
      fb = 1'b0;
      for (int i = 71; i >= 0; i--) begin
         fb = c[7] ^ i_data[i];
         c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
      end
      o_crc = c;
   end
endmodule : dwc_crc8_72

/* rtl/dwc_pkg.sv */
// Constants and types shared by the write-checksum burst controller
package dwc_pkg;
   // Link clock made by dividing the system clock
   localparam int unsigned SYS_PERIOD_NS  = 10;
   localparam int unsigned LINK_PERIOD_NS = 80;
   localparam int unsigned LINK_DIV       = LINK_PERIOD_NS / SYS_PERIOD_NS;
   localparam logic [2:0]  PH_RISE        = 3'h0;   // Link clock goes high
   localparam logic [2:0]  PH_FALL        = 3'(LINK_DIV / 2);

   // Register offsets on the software port
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_CMD   = 4'h1;
   localparam logic [3:0] REG_DATA0 = 4'h2;        // Four data words, 0x2..0x5
   localparam logic [3:0] REG_DATA3 = 4'h5;
   localparam logic [3:0] REG_MASK  = 4'h6;
   localparam logic [3:0] REG_STAT  = 4'h7;

   // Field positions
   localparam int unsigned CTL_W       = 10;       // Control word width
   localparam int unsigned CMD_GO      = 0;
   localparam int unsigned ST_BUSY     = 0;
   localparam int unsigned ST_ALERT    = 1;
   localparam int unsigned ST_REFUSED  = 2;
   localparam int unsigned ST_CRCLO    = 8;
   localparam int unsigned ST_CRCHI    = 16;

   // Device width codes
   localparam logic [1:0] W_X4  = 2'h0;
   localparam logic [1:0] W_X8  = 2'h1;
   localparam logic [1:0] W_X16 = 2'h2;

   // Cycle and transfer counts
   localparam logic [3:0] XFER_BL8  = 4'h8;        // Data transfers only
   localparam logic [3:0] XFER_CRC  = 4'ha;        // Data plus two checksum transfers
   localparam logic [3:0] XFER_HALF = 4'h4;        // First unused transfer in chop-four
   localparam logic [3:0] XFER_C0   = 4'h8;
   localparam logic [3:0] XFER_C1   = 4'h9;
   localparam logic [3:0] GAP_PRE1  = 4'h4;        // Forbidden spacing, one-clock preamble
   localparam logic [3:0] GAP_PRE2  = 4'h6;        // Forbidden spacing, two-clock preamble
   localparam logic [3:0] GAP_MAX   = 4'hf;
   localparam logic [3:0] PRE_1CK   = 4'h1;
   localparam logic [3:0] PRE_2CK   = 4'h2;
   localparam logic [9:0] CTL_RST   = 10'h000;

   // Control word, bit 0 at the bottom
   typedef struct packed {
      logic       pda;        // Per-device addressing requested
      logic       mpr_wr;     // Multipurpose register write requested
      logic       pre2;       // Two-clock write preamble
      logic       a2;         // Column bit two for chop-four
      logic       bc4;        // Chop-four burst
      logic       dbi_en;     // Write bus inversion lane in use
      logic       dm_en;      // Data mask lane in use
      logic       crc_en;     // Write checksum on
      logic [1:0] width;      // Device width code
   } dwc_cfg_t;

   // Controller states
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WAIT = 4'b0010,
      S_PRE  = 4'b0100,
      S_DATA = 4'b1000
   } dwc_state_t;

   // Pins toward the memory device
   typedef struct packed {
      logic        link_clk;  // Divided link clock
      logic        cmd_wr;    // Write command, one link clock long
      logic [2:0]  col_low;   // Low column address bits
      logic        dqs;       // Data strobe
      logic        dqs_oe;    // Strobe driven
      logic [15:0] dq;        // Data lanes
      logic [1:0]  dmi;       // Mask or inversion lanes, lower and upper byte
      logic        dq_oe;     // Data and mask lanes driven
   } dwc_pins_t;

   // Two-stage synchroniser state
   typedef struct packed {
      logic meta;
      logic stable;
   } dwc_sync_t;

   // Whole controller state
   typedef struct packed {
      dwc_state_t   st;
      logic [2:0]   ph;       // Phase inside a link clock period
      logic [3:0]   gap;      // Link clocks since last command
      logic [3:0]   cnt;      // Preamble or transfer counter
      logic [3:0]   sent;     // Transfer number now on the pins
      dwc_cfg_t     cfg;      // Software control word
      dwc_cfg_t     run;      // Control word of the burst in flight
      logic [127:0] data;
      logic [15:0]  mask;
      logic [143:0] cw;       // Code word of the burst in flight
      logic         alert;
      logic         refused;
      logic [31:0]  rdata;
      dwc_pins_t    pins;
   } dwc_regs_t;
endpackage : dwc_pkg

/* rtl/dwc_sync2.sv */
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module dwc_sync2 (
   input  wire logic i_clk_sys,   // System clock
   input  wire logic i_arst_n,    // Asynchronous reset, active low
   input  wire logic i_ce,        // Clock enable
   input  wire logic i_async,     // Asynchronous level
   output logic      o_sync       // Synchronised level
);
   import dwc_pkg::*;

   dwc_sync_t s_q;   // Register stages
   dwc_sync_t s_d;   // Next value

   // Shift the level through both stages
   always_comb begin
      s_d.meta   = i_async;
      s_d.stable = s_q.meta;
   end

   // Reset to the idle (high) level of an active-low line
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '1;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_sync = s_q.stable;
endmodule : dwc_sync2

/* rtl/dwc_wcrc_host.sv */
// Write burst controller that frames data with an 8-bit checksum for the memory device
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module dwc_wcrc_host (
   input  wire logic              i_clk_sys,  // System clock, 100 MHz
   input  wire logic              i_arst_n,   // Asynchronous reset, active low
   input  wire logic              i_ce,       // Clock enable, freezes all state except hlp_gap_q when low
   input  wire logic [3:0]        i_addr,     // Register word address
   input  wire logic [31:0]       i_wdata,    // Write data
   input  wire logic              i_wr,       // Write strobe
   input  wire logic              i_rd,       // Read strobe
   output logic      [31:0]       o_rdata,    // Read data, cycle after the strobe
   input  wire logic              i_alert_n,  // Device error line, active low
   output dwc_pkg::dwc_pins_t     o_pins      // Pins toward the device
);
   import dwc_pkg::*;

   dwc_regs_t   s_q;        // All state
   dwc_regs_t   s_d;        // Next state
   logic [7:0]  crc_lo;     // Checksum of lower code word
   logic [7:0]  crc_hi;     // Checksum of upper code word
   logic        alert_s;    // Synchronised alert line
   logic        rise;       // Link clock rising phase
   logic        fall;       // Link clock falling phase
   logic        go;         // Software start request
   logic        bad_cfg;    // Start must be refused
   logic [3:0]  forbid;     // Forbidden command spacing
   logic [3:0]  pre_len;    // Preamble length in link clocks
   logic [3:0]  n_xfer;     // Transfers in the burst

   // Lower and upper byte trees
   dwc_crc8_72 u_crc_lo (
      .i_data (s_q.cw[71:0]),
      .o_crc  (crc_lo)
   );
   dwc_crc8_72 u_crc_hi (
      .i_data (s_q.cw[143:72]),
      .o_crc  (crc_hi)
   );

   // Alert line crosses into the system clock
   dwc_sync2 u_alert_sync (
      .i_clk_sys (i_clk_sys),
      .i_arst_n  (i_arst_n),
      .i_ce      (i_ce),
      .i_async   (i_alert_n),
      .o_sync    (alert_s)
   );

   // Build the code word(s) as the trees must see them
   function automatic logic [143:0] codeword(input dwc_cfg_t c, input logic [127:0] d,
                                             input logic [15:0] m);
      logic [143:0] w;
      logic [7:0]   byt;
      w   = '1;
      byt = 8'h00;
      if (c.width == W_X4) begin
         w[31:0] = d[31:0];
      end else begin
         w[63:0] = d[63:0];
         if (c.dm_en || c.dbi_en) begin
            w[71:64] = m[7:0];
         end
         if (c.width == W_X16) begin
            w[135:72] = d[127:64];
            if (c.dm_en || c.dbi_en) begin
               w[143:136] = m[15:8];
            end
         end
      end
      // Chop-four keeps one half per lane in the low inputs, rest ones
      if (c.bc4) begin
         for (int b = 0; b < 18; b++) begin
            byt          = w[8*b +: 8];
            w[8*b +: 8]  = {4'hf, c.a2 ? byt[7:4] : byt[3:0]};
         end
      end
      return w;
   endfunction : codeword

   // One transfer on all lanes: {upper mask, lower mask, dq[15:0]}
   function automatic logic [17:0] beat(input dwc_cfg_t c, input logic [143:0] w,
                                        input logic [15:0] crc, input logic [3:0] t);
      logic [17:0] b;
      b = '1;
      if (t < XFER_BL8) begin
         for (int n = 0; n < 8; n++) begin
            b[n]     = w[8*n + int'(t)];
            b[n + 8] = w[8*n + 72 + int'(t)];
         end
         b[16] = w[64 + int'(t)];
         b[17] = w[136 + int'(t)];
      end else if (t == XFER_C0) begin
         for (int n = 0; n < 8; n++) begin
            if (c.width != W_X4 || n < 4) begin
               b[n] = crc[n];
            end
            if (c.width == W_X16) begin
               b[n + 8] = crc[n + 8];
            end
         end
      end else if (c.width == W_X4) begin
         b[3:0] = crc[7:4];
      end
      return b;
   endfunction : beat

   assign rise    = (s_q.ph == PH_RISE);
   assign fall    = (s_q.ph == PH_FALL);
   assign forbid  = s_q.run.pre2 ? GAP_PRE2 : GAP_PRE1;
   assign pre_len = s_q.run.pre2 ? PRE_2CK : PRE_1CK;
   assign n_xfer  = s_q.run.crc_en ? XFER_CRC : XFER_BL8;
   assign bad_cfg = (s_q.cfg.dm_en && s_q.cfg.dbi_en)
                    || (s_q.cfg.crc_en && (s_q.cfg.mpr_wr || s_q.cfg.pda));

   // Next state: register port, burst sequencer and pin drive
   always_comb begin
      logic [17:0] bt;
      bt    = '1;
      s_d   = s_q;
      go    = 1'b0;
      s_d.ph = s_q.ph + 3'h1;
      // Link clock count since the last command, saturating
      if (rise && s_q.gap != GAP_MAX) begin
         s_d.gap = s_q.gap + 4'h1;
      end
      // Software writes
      if (i_wr) begin
         case (i_addr)
            REG_CTRL: begin
               if (s_q.st == S_IDLE) begin
                  s_d.cfg = dwc_cfg_t'(i_wdata[CTL_W-1:0]);
               end
            end
            REG_CMD:  go = i_wdata[CMD_GO];
            REG_MASK: s_d.mask = i_wdata[15:0];
            REG_STAT: begin
               if (i_wdata[ST_ALERT]) begin
                  s_d.alert = 1'b0;
               end
               if (i_wdata[ST_REFUSED]) begin
                  s_d.refused = 1'b0;
               end
            end
            default: begin
               if (i_addr >= REG_DATA0 && i_addr <= REG_DATA3) begin
                  s_d.data[32*(i_addr - REG_DATA0) +: 32] = i_wdata;
               end
            end
         endcase
      end
      // Software reads, answer stands one cycle, unmapped reads zero
      s_d.rdata = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            REG_CTRL: s_d.rdata[CTL_W-1:0] = s_q.cfg;
            REG_MASK: s_d.rdata[15:0]      = s_q.mask;
            REG_STAT: begin
               s_d.rdata[ST_BUSY]          = (s_q.st != S_IDLE);
               s_d.rdata[ST_ALERT]         = s_q.alert;
               s_d.rdata[ST_REFUSED]       = s_q.refused;
               s_d.rdata[ST_CRCLO +: 8]    = crc_lo;
               s_d.rdata[ST_CRCHI +: 8]    = crc_hi;
            end
            default: begin
               if (i_addr >= REG_DATA0 && i_addr <= REG_DATA3) begin
                  s_d.rdata = s_q.data[32*(i_addr - REG_DATA0) +: 32];
               end
            end
         endcase
      end
      // Device error seen; a new alert wins over a clear in the same cycle
      if (!alert_s) begin
         s_d.alert = 1'b1;
      end
      // Start request: refused while busy or with an illegal mode mix
      if (go) begin
         if (s_q.st != S_IDLE || bad_cfg) begin
            s_d.refused = 1'b1;
         end else begin
            s_d.run = s_q.cfg;
            s_d.cw  = codeword(s_q.cfg, s_q.data, s_q.mask);
            s_d.st  = S_WAIT;
         end
      end
      // Burst sequencer
      unique case (s_q.st)
         S_IDLE: begin
         end
         S_WAIT: begin
            // Hold off one clock when spacing would hit the forbidden value
            if (rise && !(s_q.run.crc_en && (s_q.gap + 4'h1) == forbid)) begin
               s_d.st  = S_PRE;
               s_d.cnt = pre_len;
               s_d.gap = 4'h0;
            end
         end
         S_PRE: begin
            if (rise) begin
               if (s_q.cnt == 4'h1) begin
                  s_d.st  = S_DATA;
                  s_d.cnt = 4'h0;
               end else begin
                  s_d.cnt = s_q.cnt - 4'h1;
               end
            end
         end
         S_DATA: begin
            // Double data rate: one transfer per half link clock
            if (rise || fall) begin
               if (s_q.cnt == n_xfer - 4'h1) begin
                  s_d.st = S_IDLE;
               end else begin
                  s_d.cnt = s_q.cnt + 4'h1;
               end
            end
         end
         default: s_d.st = S_IDLE;
      endcase
      // Registered pins
      if (s_q.st == S_DATA) begin
         bt = beat(s_q.run, s_q.cw, {crc_hi, crc_lo}, s_q.cnt);
      end
      s_d.sent          = s_q.cnt;
      s_d.pins.link_clk = (s_q.ph < PH_FALL);
      s_d.pins.cmd_wr   = (s_q.st == S_PRE) && (s_q.gap == 4'h0);
      s_d.pins.col_low  = {s_q.run.bc4 && s_q.run.a2, 2'b00};
      s_d.pins.dqs_oe   = (s_q.st == S_PRE) || (s_q.st == S_DATA);
      s_d.pins.dqs      = (s_q.st == S_DATA) && (s_q.ph < PH_FALL);
      s_d.pins.dq_oe    = (s_q.st == S_DATA);
      s_d.pins.dq       = bt[15:0];
      s_d.pins.dmi      = bt[17:16];
   end

   // State register
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q         <= '0;
         s_q.st      <= S_IDLE;
         s_q.gap     <= GAP_MAX;
         s_q.cfg     <= dwc_cfg_t'(CTL_RST);
         s_q.pins.dq <= '1;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_pins  = s_q.pins;

   // Helper: system cycles since the last command
   logic [7:0] hlp_gap_q;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hlp_gap_q <= 8'hff;
      end else if ($rose(s_q.pins.cmd_wr)) begin
         hlp_gap_q <= 8'h01;
      end else if (hlp_gap_q != 8'hff) begin
         hlp_gap_q <= hlp_gap_q + 8'h01;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   sequence cmd_seen;
      $rose(s_q.pins.cmd_wr);
   endsequence
   sequence data_start;
      $rose(s_q.pins.dq_oe);
   endsequence

   a_cmd_space: assert property (
      cmd_seen and s_q.run.crc_en |->
         hlp_gap_q != 8'(int'(s_q.run.pre2 ? GAP_PRE2 : GAP_PRE1) * LINK_DIV))
      else $error("command spacing hits forbidden value");
   a_burst_follows: assert property (
      cmd_seen |-> ##[8:16] data_start)
      else $error("data burst did not follow command");
   a_xfer9_ones: assert property (
      s_q.pins.dq_oe && s_q.sent == XFER_C1 && s_q.run.width != W_X4 |->
         s_q.pins.dq == 16'hffff && s_q.pins.dmi == 2'h3)
      else $error("transfer nine not all ones");
   a_crc_lane_x8: assert property (
      s_q.pins.dq_oe && s_q.sent == XFER_C0 && s_q.run.width != W_X4 |->
         s_q.pins.dq[7:0] == crc_lo && s_q.pins.dmi == 2'h3)
      else $error("checksum not on lanes in transfer eight");
   a_x4_upper_ones: assert property (
      s_q.st != S_IDLE && s_q.run.width == W_X4 |-> &s_q.cw[71:32])
      else $error("upper code word bits not ones");
   a_bc4_ones: assert property (
      s_q.pins.dq_oe && s_q.run.bc4 && s_q.sent >= XFER_HALF && s_q.sent < XFER_BL8 |->
         s_q.pins.dq == 16'hffff && s_q.pins.dmi == 2'h3)
      else $error("chop-four unused transfer not ones");
   a_bl8_col_zero: assert property (
      s_q.pins.cmd_wr && s_q.run.crc_en && !s_q.run.bc4 |-> s_q.pins.col_low == 3'h0)
      else $error("eight-burst column bits not zero");
   a_no_dm_dbi: assert property (
      cmd_seen |-> !(s_q.run.dm_en && s_q.run.dbi_en))
      else $error("mask and inversion issued together");
   a_no_mpr_pda: assert property (
      cmd_seen and s_q.run.crc_en |-> !(s_q.run.mpr_wr || s_q.run.pda))
      else $error("register write or per-device mode with checksum");
endmodule : dwc_wcrc_host

/* sim/dwc_dev_model.sv */
// Memory device model that receives write bursts and checks their checksum
`timescale 1ns/10ps
module dwc_dev_model (
   input  wire logic               i_clk_sys,  // System clock used to sample the lanes
   input  wire dwc_pkg::dwc_pins_t i_pins,     // Pins from the controller
   input  wire logic [1:0]         i_width,    // Width code set in the mode register
   input  wire logic               i_crc_en,   // Write checksum set in the mode register
   input  wire logic               i_dm_en,    // Data mask set in the mode register
   input  wire logic               i_inject,   // Report a failure on the next burst
   output logic                    o_alert_n   // Error line, active low
);
   import dwc_pkg::*;
   logic [17:0]  xf [10];        // Each transfer as {dmi, dq}
   logic [143:0] cw;             // Code words as received, inversion not undone
   logic [15:0]  crc;            // Checksums worked out here
   logic [15:0]  rx;             // Checksums sent by the controller
   logic [2:0]   col  = 3'h0;    // Low column bits seen with the command
   int           n    = 0;       // Data cycles counted in this burst
   int           last = 0;       // Transfers in the last burst
   int           hold = 0;       // Cycles left of the error pulse
   int           stored = 0;     // Bursts written into the array

   // Serial checksum, first bit is bit 71, register starts at zero
   function automatic logic [7:0] crc8(input logic [71:0] d);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 71; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ (((r[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
      end
      return r;
   endfunction : crc8

   // Unpack the lanes into the two code words and their checksums
   always_comb begin
      cw = '1;
      for (int t = 0; t < 8; t++) begin
         for (int k = 0; k < 8; k++) begin
            cw[8*k+t]    = xf[t][k];
            cw[72+8*k+t] = xf[t][8+k];
         end
         cw[64+t]  = xf[t][16];
         cw[136+t] = xf[t][17];
      end
      if (i_width == W_X4) begin
         cw[71:32] = '1;
      end
      crc = {crc8(cw[143:72]), crc8(cw[71:0])};
      rx  = (i_width == W_X4) ? {8'hff, xf[9][3:0], xf[8][3:0]} : xf[8][15:0];
   end

   // Sample each transfer in its middle, judge the burst when the lanes are let go
   always @(posedge i_clk_sys) begin
      if (hold > 0) hold <= hold - 1;
      if (i_pins.cmd_wr) col <= i_pins.col_low;
      if (i_pins.dq_oe) begin
         n <= n + 1;
         if (n % 4 == 2 && n < 40) xf[n / 4] <= {i_pins.dmi, i_pins.dq};
      end else if (n > 0) begin
         n    <= 0;
         last <= n / 4;
         // Compare only while the checksum is on
         if (i_crc_en && (i_inject || rx[7:0] !== crc[7:0] ||
             (i_width == W_X16 && rx[15:8] !== crc[15:8]))) begin
            hold <= 6;
            // With the mask on a failing write never reaches the array
            if (!i_dm_en) stored <= stored + 1;
         end else begin
            stored <= stored + 1;
         end
      end
   end
   assign o_alert_n = (hold == 0);
endmodule : dwc_dev_model

/* sim/tb_dwc_wcrc_host.sv */
// Self-checking bench for the write-checksum burst controller
`timescale 1ns/10ps
module tb_dwc_wcrc_host;
   import dwc_pkg::*;
   localparam logic [127:0] DAT = 128'h0123456789abcdeffedcba9876543210;  // Burst data
   localparam logic [15:0]  MSK = 16'h5ac3;                               // Mask lane bits
   logic        clk_sys = 1'b0;   // System clock
   logic        arst_n  = 1'b0;   // Reset, active low
   logic [3:0]  addr    = 4'h0;   // Register address
   logic [31:0] wdata   = 32'h0;  // Write data
   logic        wr_s    = 1'b0;   // Write strobe
   logic        rd_s    = 1'b0;   // Read strobe
   logic [31:0] rdata;            // Read data
   logic        alert_n;          // Error line from the model
   dwc_pins_t   pins;             // Pins toward the model
   logic [1:0]  mw      = 2'h0;   // Model width code
   logic        mcrc    = 1'b0;   // Model checksum enable
   logic        mdm     = 1'b0;   // Model data mask enable
   logic        inject  = 1'b0;   // Model reports a failure
   logic [31:0] st;               // Last status word read
   int          mismatches  = 0;  // Mismatches found
   int          comparisons = 0;  // Comparisons made
   int          cycles      = 0;  // Cycles run

   always #5 clk_sys = ~clk_sys;

   dwc_wcrc_host dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(1'b1), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_alert_n(alert_n),
      .o_pins(pins));
   dwc_dev_model m (.i_clk_sys(clk_sys), .i_pins(pins), .i_width(mw), .i_crc_en(mcrc),
      .i_dm_en(mdm), .i_inject(inject), .o_alert_n(alert_n));

   // Print the counts and the verdict, then stop
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // Cut a hang short
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test;
      end
   end

   // Compare one value with its expectation
   task automatic check(input logic [143:0] got, input logic [143:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_sys);
      wr_s  <= 1'b0;
   endtask : wr

   // One-cycle register read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask : rd

   // Load data, set control, start and wait for the end of the burst
   task automatic burst(input logic [9:0] c);
      mw   <= c[1:0];
      mcrc <= c[2];
      mdm  <= c[3];
      for (int i = 0; i < 4; i++) wr(REG_DATA0 + 4'(i), DAT[32*i +: 32]);
      wr(REG_MASK, {16'h0, MSK});
      wr(REG_CTRL, {22'h0, c});
      wr(REG_CMD, 32'h1);
      for (int i = 0; i < 40; i++) begin
         rd(REG_STAT, st);
         if (st[ST_BUSY] !== 1'b1) break;
      end
      repeat (16) @(posedge clk_sys);
      rd(REG_STAT, st);
   endtask : burst

   // Reset values, an unmapped address and idle lanes
   task automatic t_reset;
      rd(REG_CTRL, st);
      check(st, 32'h0);
      rd(4'h9, st);
      check(st, 32'h0);
      check(pins.dq, 16'hffff);
   endtask : t_reset

   // Eight-bit width with mask lane in use
   task automatic t_x8;
      logic [71:0] w;
      w = {MSK[7:0], DAT[63:0]};
      burst(10'h00d);
      check(m.cw[71:0], w);
      check(m.xf[8][7:0], m.crc8(w));
      check(m.xf[9], 18'h3ffff);
      check(st[15:8], m.crc8(w));
      check(st[ST_ALERT], 1'b0);
      check(m.col, 3'h0);
   endtask : t_x8

   // Sixteen-bit width, mask lanes unused, then with inversion lanes
   task automatic t_x16;
      logic [71:0] hi;
      hi = {8'hff, DAT[127:64]};
      burst(10'h006);
      check(m.cw, {hi, 8'hff, DAT[63:0]});
      check(m.xf[8][15:8], m.crc8(hi));
      check(st[23:16], m.crc8(hi));
      check(m.xf[9], 18'h3ffff);
      hi = {MSK[15:8], DAT[127:64]};
      burst(10'h016);
      check(m.cw[143:64], {hi, MSK[7:0]});
      check(st[23:16], m.crc8(hi));
   endtask : t_x16

   // Four-bit width with the two-clock preamble
   task automatic t_x4;
      logic [7:0] e;
      e = m.crc8({40'hffffffffff, DAT[31:0]});
      burst(10'h084);
      check(m.cw[31:0], DAT[31:0]);
      check(m.xf[8][3:0], e[3:0]);
      check(m.xf[9][3:0], e[7:4]);
      check(st[15:8], e);
   endtask : t_x4

   // Chop-four burst with the upper half first
   task automatic t_bc4;
      logic [71:0] w;
      logic [71:0] v;
      w = '1;
      v = '1;
      for (int i = 0; i < 8; i++) w[8*i +: 8] = {4'hf, DAT[8*i+4 +: 4]};
      for (int i = 0; i < 8; i++) v[8*i +: 8] = {4'hf, DAT[8*i +: 4]};
      burst(10'h065);
      check(m.col, 3'h4);
      check(m.cw[71:0], w);
      check(m.xf[5], 18'h3ffff);
      check(st[15:8], m.crc8(w));
      // Lower half first
      burst(10'h025);
      check(m.col, 3'h0);
      check(m.cw[71:0], v);
      check(st[15:8], m.crc8(v));
   endtask : t_bc4

   // Checksum off gives eight transfers
   task automatic t_plain;
      burst(10'h001);
      check(32'(m.last), 32'h8);
      check(st[ST_ALERT], 1'b0);
   endtask : t_plain

   // Forbidden combinations are refused and the flag clears
   task automatic t_refuse;
      logic [9:0] bad [3] = '{10'h01d, 10'h105, 10'h205};
      for (int i = 0; i < 3; i++) begin
         burst(bad[i]);
         check(st[ST_REFUSED], 1'b1);
         wr(REG_STAT, 32'h4);
         rd(REG_STAT, st);
         check(st[ST_REFUSED], 1'b0);
      end
   endtask : t_refuse

   // Device error is recorded and cleared
   task automatic t_alert;
      int s;
      s = m.stored;
      inject <= 1'b1;
      burst(10'h00d);
      check(st[ST_ALERT], 1'b1);
      check(32'(m.stored), 32'(s));
      inject <= 1'b0;
      wr(REG_STAT, 32'h2);
      rd(REG_STAT, st);
      check(st[ST_ALERT], 1'b0);
   endtask : t_alert

   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset;
      t_x8;
      t_x16;
      t_x4;
      t_bc4;
      t_plain;
      t_refuse;
      t_alert;
      end_of_test;
   end
endmodule : tb_dwc_wcrc_host
